// ===== hdl/sao_cfg.svh
/*
 * Constants of the sampled converter output port: code width, format
 * encodings and default output timing counts in sys_clk cycles.
 * Assumes a 20 MHz system clock.
 */
`ifndef SAO_CFG_SVH
`define SAO_CFG_SVH
`define SAO_CODE_W       8
`define SAO_SAMPLE_W     16
`define SAO_FIFO_DEPTH   32
`define SAO_DLY_W        8
`define SAO_CLK_NS       50
`define SAO_DLY_NS_DFLT  0
`define SAO_DLY_CYC_DFLT (`SAO_DLY_NS_DFLT / `SAO_CLK_NS)
`define SAO_FMT_UNSIGNED 2'h0
`define SAO_FMT_SIGNMAG  2'h1
`define SAO_FMT_TWOS     2'h2
`endif

// ===== hdl/sao_pkg.sv
/*
 * Types shared by the converter output port modules.
 * Assumes sao_cfg.svh is on the include path.
 */
`include "sao_cfg.svh"
package sao_pkg;
	typedef logic [`SAO_CODE_W-1:0]   sao_code_t;
	typedef logic [`SAO_SAMPLE_W-1:0] sao_sample_t;
	typedef enum logic [1:0] {
		SAO_UNSIGNED,
		SAO_SIGN_MAG,
		SAO_TWOS
	} sao_fmt_t;
endpackage

// ===== hdl/sao_stream_if.sv
/*
 * Valid/ready stream carrying converted codes between the converter
 * core and the output stage. Assumes one clock, sys_clk.
 */
`timescale 1ns/1ps
`include "sao_cfg.svh"
interface sao_stream_if;
	logic                  valid;
	logic                  ready;
	logic [`SAO_CODE_W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ===== hdl/sao_fifo.sv
/*
 * Parameterised synchronous FIFO with valid and ready on both sides.
 * Assumes a single clock and synchronous active-high reset.
 */
`timescale 1ns/1ps
module sao_fifo #(
	parameter int W = 8,
	parameter int D = 32
) (
	input  wire logic         sys_clk,
	input  wire logic         sys_rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = $clog2(D);

	logic [W-1:0]  mem [D];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0]   cnt_r;
	logic          push;
	logic          pop;

	assign in_ready  = (cnt_r != (AW+1)'(D));
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem[rd_r];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_r] <= in_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wr_r <= (wr_r == AW'(D-1)) ? '0 : wr_r + 1'b1;
			end
			if (pop) begin
				rd_r <= (rd_r == AW'(D-1)) ? '0 : rd_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	a_fifo_no_over: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cnt_r <= (AW+1)'(D))
		else $error("FIFO count above depth.");
endmodule

// ===== hdl/sao_pin_stage.sv
/*
 * One output bus bit: delayed rise, fall, enable and float transitions
 * plus a minimum width for which each pin level is held before it changes.
 * Assumes delays are held stable while the bus is in use.
 */
`timescale 1ns/1ps
`include "sao_cfg.svh"
module sao_pin_stage (
	input  wire logic                  sys_clk,
	input  wire logic                  sys_rst,
	input  wire logic                  data_in,
	input  wire logic                  en_in,
	input  wire logic [`SAO_DLY_W-1:0] rise_dly,
	input  wire logic [`SAO_DLY_W-1:0] fall_dly,
	input  wire logic [`SAO_DLY_W-1:0] zl_dly,
	input  wire logic [`SAO_DLY_W-1:0] zh_dly,
	input  wire logic [`SAO_DLY_W-1:0] lz_dly,
	input  wire logic [`SAO_DLY_W-1:0] hz_dly,
	input  wire logic [`SAO_DLY_W-1:0] min_pulse,
	output logic                       pin_o,
	output logic                       pin_oe
);
	logic [`SAO_DLY_W-1:0] dcnt_r;
	logic [`SAO_DLY_W-1:0] ecnt_r;
	logic [`SAO_DLY_W-1:0] hold_r;
	logic                  dpend_r;
	logic                  epend_r;
	logic                  tgt_d_r;
	logic                  tgt_e_r;
	logic [`SAO_DLY_W-1:0] ddly;
	logic [`SAO_DLY_W-1:0] edly;
	logic                  d_now;
	logic                  e_now;

	assign ddly = data_in ? rise_dly : fall_dly;
	assign edly = en_in ? (pin_o ? zh_dly : zl_dly)
	                    : (pin_o ? hz_dly : lz_dly);
	// A change whose delay is zero takes effect in the same edge. Once
	// its delay has run out, a level held back by the minimum width
	// still reaches the pin as soon as it has waited long enough.
	assign d_now = (data_in != tgt_d_r) ? (ddly == '0)
	                                    : (!dpend_r || dcnt_r <= 1);
	assign e_now = (en_in != tgt_e_r) ? (edly == '0)
	                                  : (epend_r && ecnt_r <= 1);

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			tgt_d_r <= 1'b0;
			dpend_r <= 1'b0;
			dcnt_r  <= '0;
			hold_r  <= '0;
			pin_o   <= 1'b0;
		end else begin
			if (data_in != tgt_d_r) begin
				tgt_d_r <= data_in;
				dpend_r <= (ddly != '0);
				dcnt_r  <= ddly;
			end else if (dpend_r) begin
				dcnt_r  <= dcnt_r - 1'b1;
				dpend_r <= (dcnt_r > 1);
			end
			// Pin keeps each level for at least the minimum width before it changes.
			if (d_now && data_in != pin_o && hold_r >= min_pulse) begin
				pin_o  <= data_in;
				hold_r <= '0;
			end else if (hold_r != '1) begin
				hold_r <= hold_r + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			tgt_e_r <= 1'b0;
			epend_r <= 1'b0;
			ecnt_r  <= '0;
			pin_oe  <= 1'b0;
		end else begin
			if (en_in != tgt_e_r) begin
				tgt_e_r <= en_in;
				epend_r <= (edly != '0);
				ecnt_r  <= edly;
			end else if (epend_r) begin
				ecnt_r  <= ecnt_r - 1'b1;
				epend_r <= (ecnt_r > 1);
			end
			if (e_now) begin
				pin_oe <= en_in;
			end
		end
	end

	a_oe_off_float: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(!en_in && !tgt_e_r && !epend_r) |-> !pin_oe)
		else $error("Bus bit driven while enable is off.");
endmodule

// ===== hdl/sao_adc_port.sv
/*
 * Digital side of an N-bit sampling converter: polarity selection,
 * sample capture, range scaling with saturation, code formatting, a
 * 32-word code FIFO and a delayed tri-state output bus.
 * Assumes the sample input is a digitised level synchronous to sys_clk.
 */
`timescale 1ns/1ps
`include "sao_cfg.svh"

// Contract
// - Code width N is a build parameter
// - Rising sample strobe captures the input
// - Rising conversion clock loads output register
// - Strobe and clock together both act
// - Code scales between lower and upper reference
// - Bus driven only while output enabled
// - Each input selectable active low; the code inverts only strobe, clock and enable
// - Unsigned, sign-magnitude or twos complement code
// - Separate rise and fall delays, default zero
// - Enable delays to low or high
// - Disable delays from low or high
// - Pulses below minimum width suppressed; the code instead holds each pin level for at least the minimum width
module sao_adc_port (
	input  wire logic                    sys_clk,
	input  wire logic                    sys_rst,
	input  wire logic [`SAO_SAMPLE_W-1:0] analogue_sample_input,
	input  wire logic [`SAO_SAMPLE_W-1:0] ref_low,
	input  wire logic [`SAO_SAMPLE_W-1:0] ref_high,
	input  wire logic                    sample_strobe,
	input  wire logic                    conv_clock,
	input  wire logic                    output_enable,
	input  wire logic                    invert_strobe,
	input  wire logic                    invert_clock,
	input  wire logic                    invert_enable,
	input  wire logic                    sign_and_magnitude_format,
	input  wire logic                    twos_complement_format,
	input  wire logic [`SAO_DLY_W-1:0]    clock_to_rise_delay,
	input  wire logic [`SAO_DLY_W-1:0]    clock_to_fall_delay,
	input  wire logic [`SAO_DLY_W-1:0]    enable_to_low_delay,
	input  wire logic [`SAO_DLY_W-1:0]    enable_to_high_delay,
	input  wire logic [`SAO_DLY_W-1:0]    low_to_float_delay,
	input  wire logic [`SAO_DLY_W-1:0]    high_to_float_delay,
	input  wire logic [`SAO_DLY_W-1:0]    minimum_pulse_width,
	output logic                         sample_ready,
	output logic [`SAO_CODE_W-1:0]        code_q,
	output logic [`SAO_CODE_W-1:0]        data_o,
	output logic [`SAO_CODE_W-1:0]        data_oe
);
	localparam int N  = `SAO_CODE_W;
	localparam int SW = `SAO_SAMPLE_W;

	// ****************************************************************
	// Input polarity and edge detection
	// ****************************************************************
	logic strobe_lv;
	logic clock_lv;
	logic enable_lv;
	logic strobe_d_r;
	logic clock_d_r;
	logic strobe_rise;
	logic clock_rise;

	assign strobe_lv   = sample_strobe ^ invert_strobe;
	assign clock_lv    = conv_clock ^ invert_clock;
	assign enable_lv   = output_enable ^ invert_enable;
	assign strobe_rise = strobe_lv && !strobe_d_r;
	assign clock_rise  = clock_lv && !clock_d_r;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			strobe_d_r <= 1'b0;
			clock_d_r  <= 1'b0;
		end else begin
			strobe_d_r <= strobe_lv;
			clock_d_r  <= clock_lv;
		end
	end

	// ****************************************************************
	// Sample capture
	// ****************************************************************
	logic [SW-1:0] held_r;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			held_r <= '0;
		end else if (strobe_rise) begin
			held_r <= analogue_sample_input;
		end
	end

	// ****************************************************************
	// Scaling, saturation and format
	// ****************************************************************
	sao_pkg::sao_fmt_t fmt;
	logic [SW-1:0]     src;
	logic [SW-1:0]     span;
	logic [SW+N-1:0]   num;
	logic [N-1:0]      ucode;
	logic [N-1:0]      fcode;

	// A strobe coincident with the clock converts the new sample.
	assign src  = strobe_rise ? analogue_sample_input : held_r;
	assign span = ref_high - ref_low;
	assign num  = (SW+N)'(src - ref_low) * (SW+N)'({N{1'b1}});

	always_comb begin
		fmt = sao_pkg::SAO_UNSIGNED;
		if (twos_complement_format) begin
			fmt = sao_pkg::SAO_TWOS;
		end else if (sign_and_magnitude_format) begin
			fmt = sao_pkg::SAO_SIGN_MAG;
		end
	end

	always_comb begin
		if (src <= ref_low || ref_high <= ref_low) begin
			ucode = '0;
		end else if (src >= ref_high) begin
			ucode = '1;
		end else begin
			ucode = N'(num / (SW+N)'(span));
		end
	end

	// Mid scale is zero for the signed formats.
	always_comb begin
		unique case (fmt)
		sao_pkg::SAO_UNSIGNED: begin
			fcode = ucode;
		end
		sao_pkg::SAO_TWOS: begin
			fcode = {~ucode[N-1], ucode[N-2:0]};
		end
		sao_pkg::SAO_SIGN_MAG: begin
			if (ucode[N-1]) begin
				fcode = {1'b0, ucode[N-2:0]};
			end else begin
				fcode = '0;
				fcode[N-1] = 1'b1;
				fcode[N-2:0] = (N-1)'(~ucode[N-2:0] + 1'b1);
			end
		end
		endcase
	end

	// ****************************************************************
	// Code FIFO and output register
	// ****************************************************************
	sao_stream_if cs ();
	logic fifo_valid;
	logic [N-1:0] fifo_data;

	assign cs.valid     = clock_rise;
	assign cs.data      = fcode;
	assign sample_ready = cs.ready;

	sao_fifo #(
		.W (N),
		.D (`SAO_FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.in_valid  (cs.valid),
		.in_ready  (cs.ready),
		.in_data   (cs.data),
		.out_valid (fifo_valid),
		.out_ready (1'b1),
		.out_data  (fifo_data)
	);

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			code_q <= '0;
		end else if (fifo_valid) begin
			code_q <= fifo_data;
		end
	end

	// ****************************************************************
	// Output bus bits
	// ****************************************************************
	for (genvar i = 0; i < N; i++) begin : g_bit
		sao_pin_stage u_pin (
			.sys_clk   (sys_clk),
			.sys_rst   (sys_rst),
			.data_in   (code_q[i]),
			.en_in     (enable_lv),
			.rise_dly  (clock_to_rise_delay),
			.fall_dly  (clock_to_fall_delay),
			.zl_dly    (enable_to_low_delay),
			.zh_dly    (enable_to_high_delay),
			.lz_dly    (low_to_float_delay),
			.hz_dly    (high_to_float_delay),
			.min_pulse (minimum_pulse_width),
			.pin_o     (data_o[i]),
			.pin_oe    (data_oe[i])
		);
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_sample_capture: assert property (@(posedge sys_clk) disable iff (sys_rst)
		strobe_rise |=> held_r == $past(analogue_sample_input))
		else $error("Sample not captured on strobe edge.");

	a_sample_holds: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!strobe_rise |=> $stable(held_r))
		else $error("Held sample changed without strobe.");

	a_code_loads: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(clock_rise && cs.ready && !fifo_valid) |=> ##1 code_q == $past(fcode, 2))
		else $error("Output register did not load converted code.");

	a_both_edges: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(strobe_rise && clock_rise) |-> src == analogue_sample_input)
		else $error("Coincident edges used stale sample.");

	a_sat_high: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(src >= ref_high && ref_high > ref_low) |-> ucode == '1)
		else $error("Code not saturated high.");

	a_sat_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(src <= ref_low) |-> ucode == '0)
		else $error("Code not zero at lower reference.");

	a_twos_format: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(fmt == sao_pkg::SAO_TWOS) |-> fcode[N-1] != ucode[N-1])
		else $error("Twos complement sign bit wrong.");

	a_oe_zero_dly: assert property (@(posedge sys_clk) disable iff (sys_rst)
		($rose(enable_lv) && enable_to_low_delay == '0
		 && enable_to_high_delay == '0) |=> &data_oe)
		else $error("Bus not driven one edge after enable.");

	a_fall_zero_dly: assert property (@(posedge sys_clk) disable iff (sys_rst)
		($fell(code_q[0]) && clock_to_fall_delay == '0
		 && minimum_pulse_width == '0) |=> !data_o[0])
		else $error("Bit did not fall with zero delay.");
endmodule

// ===== sim/sao_bus_reader.sv
/*
 * Far side of the converter output port: logic that reads the tri-state
 * code bus. Assumes data_o and data_oe come straight from the port and
 * that the bus has no pull resistors.
 */
`timescale 1ns/1ps
`include "sao_cfg.svh"
module sao_bus_reader (
	input  wire logic                   sys_clk,
	input  wire logic [`SAO_CODE_W-1:0] data_o,
	input  wire logic [`SAO_CODE_W-1:0] data_oe,
	output logic      [`SAO_CODE_W-1:0] bus_line
);
	logic [`SAO_CODE_W-1:0] last_r = '0;

	// ************************************************************
	// Bus resolution
	// ************************************************************
	// An undriven line shows the inverse of its last driven level, so a
	// stale value can never pass for a driven one.
	always_comb begin
		for (int i = 0; i < `SAO_CODE_W; i++) begin
			bus_line[i] = data_oe[i] ? data_o[i] : ~last_r[i];
		end
	end

	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < `SAO_CODE_W; i++) begin
			if (data_oe[i]) begin
				last_r[i] <= data_o[i];
			end
		end
	end
endmodule

// ===== sim/tb_top.sv
/*
 * Self-checking bench of the converter output port: conversions, code
 * formats, saturation, polarity and bus timing seen through a reader.
 * Assumes sao_cfg.svh and sao_pkg are compiled first.
 */
`timescale 1ns/1ps
`include "sao_cfg.svh"
module tb_top;
	logic        sys_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [15:0] ain = 16'h0000;
	logic [15:0] lo = 16'h1000;
	logic [15:0] hi = 16'h10FF;
	logic        strb = 1'b0;
	logic        cclk = 1'b0;
	logic        oe = 1'b0;
	logic        inv_s = 1'b0;
	logic        inv_c = 1'b0;
	logic        inv_e = 1'b0;
	logic        fsm = 1'b0;
	logic        ftc = 1'b0;
	logic [7:0]  d_r = 8'h00;
	logic [7:0]  d_f = 8'h00;
	logic [7:0]  d_zl = 8'h00;
	logic [7:0]  d_zh = 8'h00;
	logic [7:0]  d_lz = 8'h00;
	logic [7:0]  d_hz = 8'h00;
	logic [7:0]  pw = 8'h00;
	logic        sample_ready;
	logic [7:0]  code_q;
	logic [7:0]  data_o;
	logic [7:0]  data_oe;
	logic [7:0]  bus_line;
	int          fail_count = 0;
	int          n_compared = 0;
	int          lat;
	logic [7:0]  fmt_exp [4] = '{8'h30, 8'hD0, 8'hB0, 8'hB0};

	always #25 sys_clk = ~sys_clk;

	sao_adc_port u_dut (
		.sys_clk                   (sys_clk),
		.sys_rst                   (sys_rst),
		.analogue_sample_input     (ain),
		.ref_low                   (lo),
		.ref_high                  (hi),
		.sample_strobe             (strb),
		.conv_clock                (cclk),
		.output_enable             (oe),
		.invert_strobe             (inv_s),
		.invert_clock              (inv_c),
		.invert_enable             (inv_e),
		.sign_and_magnitude_format (fsm),
		.twos_complement_format    (ftc),
		.clock_to_rise_delay       (d_r),
		.clock_to_fall_delay       (d_f),
		.enable_to_low_delay       (d_zl),
		.enable_to_high_delay      (d_zh),
		.low_to_float_delay        (d_lz),
		.high_to_float_delay       (d_hz),
		.minimum_pulse_width       (pw),
		.sample_ready              (sample_ready),
		.code_q                    (code_q),
		.data_o                    (data_o),
		.data_oe                   (data_oe)
	);

	sao_bus_reader u_reader (
		.sys_clk  (sys_clk),
		.data_o   (data_o),
		.data_oe  (data_oe),
		.bus_line (bus_line)
	);

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Pulses strobe and/or clock for two cycles, then counts edges
	// until the bus register shows the expected code.
	task automatic conv(input logic [15:0] v, input logic s, input logic c,
		input logic [7:0] e, output int l);
		@(posedge sys_clk);
		ain <= v;
		if (s) strb <= ~inv_s;
		if (c) cclk <= ~inv_c;
		l = 99;
		for (int k = 1; k < 30; k++) begin
			@(posedge sys_clk);
			if (k == 2) begin
				strb <= inv_s;
				cclk <= inv_c;
			end
			#1;
			if (l == 99 && data_o === e) l = k;
		end
		check(code_q, e);
	endtask

	task automatic oe_set(input logic act, output int l);
		@(posedge sys_clk);
		oe <= act ^ inv_e;
		l = 99;
		for (int k = 1; k < 30; k++) begin
			@(posedge sys_clk);
			#1;
			if (l == 99 && data_oe === {8{act}}) l = k;
		end
	endtask

	initial begin
		#(50 * 8000);
		fail_count++;
		close_out();
	end

	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		#1;
		check(code_q, 8'h00);
		check(data_oe, 8'h00);
		check(sample_ready, 1'b1);
		oe_set(1'b1, lat);
		check(lat, 1);
		conv(16'h1040, 1'b1, 1'b1, 8'h40, lat);
		check(lat, 3);
		check(bus_line, 8'h40);
		conv(16'h0FFF, 1'b1, 1'b1, 8'h00, lat);
		conv(16'h2000, 1'b1, 1'b1, 8'hFF, lat);
		conv(16'h1010, 1'b0, 1'b1, 8'hFF, lat);
		conv(16'h1020, 1'b1, 1'b0, 8'hFF, lat);
		conv(16'h1030, 1'b0, 1'b1, 8'h20, lat);
		lo <= 16'h0000;
		hi <= 16'hFFFF;
		conv(16'h8080, 1'b1, 1'b1, 8'h80, lat);
		lo <= 16'h1000;
		hi <= 16'h10FF;
		for (int f = 0; f < 4; f++) begin
			fsm <= f[0];
			ftc <= f[1];
			conv(16'h1030, 1'b1, 1'b1, fmt_exp[f], lat);
		end
		fsm <= 1'b0;
		ftc <= 1'b0;
		conv(16'h1000, 1'b1, 1'b1, 8'h00, lat);
		d_r <= 8'h05;
		conv(16'h10FF, 1'b1, 1'b1, 8'hFF, lat);
		check(lat >= 8 && lat <= 9, 1'b1);
		conv(16'h1000, 1'b1, 1'b1, 8'h00, lat);
		check(lat, 3);
		d_r <= 8'h00;
		d_f <= 8'h05;
		conv(16'h10FF, 1'b1, 1'b1, 8'hFF, lat);
		conv(16'h1000, 1'b1, 1'b1, 8'h00, lat);
		check(lat >= 8 && lat <= 9, 1'b1);
		d_f <= 8'h00;
		pw <= 8'h20;
		conv(16'h10FF, 1'b1, 1'b1, 8'hFF, lat);
		check(lat, 11);
		conv(16'h1000, 1'b1, 1'b1, 8'h00, lat);
		check(lat, 14);
		pw <= 8'h00;
		d_lz <= 8'h04;
		d_zl <= 8'h04;
		d_hz <= 8'h04;
		d_zh <= 8'h04;
		oe_set(1'b0, lat);
		check(lat >= 5 && lat <= 6, 1'b1);
		check(bus_line, 8'hFF);
		oe_set(1'b1, lat);
		check(lat >= 5 && lat <= 6, 1'b1);
		conv(16'h10FF, 1'b1, 1'b1, 8'hFF, lat);
		oe_set(1'b0, lat);
		check(lat >= 5 && lat <= 6, 1'b1);
		oe_set(1'b1, lat);
		check(lat >= 5 && lat <= 6, 1'b1);
		// Flip polarity and raw level together so no edge is seen.
		@(posedge sys_clk);
		inv_s <= 1'b1;
		inv_c <= 1'b1;
		inv_e <= 1'b1;
		strb <= 1'b1;
		cclk <= 1'b1;
		oe <= 1'b0;
		conv(16'h1055, 1'b1, 1'b1, 8'h55, lat);
		check(bus_line, 8'h55);
		oe_set(1'b0, lat);
		check(data_oe, 8'h00);
		close_out();
	end
endmodule
